// [logic/lkr_key_range.sv]
// Purpose: Local four-key range, bias and lock interpreter
// Assumes: Keys active high and synchronous to core_clk
// Notes:   APB slave, one wait state on every access
//
// Operation
// - Range values only scale the bar graph.
// - Range values never touch bus output or numeric display.
// - Counting zero-up press raises lower range by one digit.
// - Counting zero-down press lowers lower range by one digit.
// - Counting span-up press raises upper range by one digit.
// - Counting span-down press lowers upper range by one digit.
// - First single press only wakes display; later presses count.
// - Held key steps slowly, then faster.
// - Key press enters calibration view; back to measurement after 2 s.
// - Zero-up plus zero-down twice captures pressure as lower range.
// - Span-up plus span-down twice captures pressure as upper range.
// - Zero-up plus span-up twice captures pressure as bias.
// - Zero-up plus span-up once shows stored bias.
// - Zero-down plus span-down twice clears bias.
// - Bias corrects only the display, never the bus output.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module lkr_key_range #(
  parameter int VIEW_CYC  = lkr_pkg::VIEW_MS * lkr_pkg::CLK_KHZ,
  parameter int COMBO_CYC = lkr_pkg::COMBO_MS * lkr_pkg::CLK_KHZ,
  parameter int GAP_CYC   = lkr_pkg::GAP_MS * lkr_pkg::CLK_KHZ,
  parameter int SLOW_CYC  = lkr_pkg::SLOW_MS * lkr_pkg::CLK_KHZ,
  parameter int FAST_CYC  = lkr_pkg::FAST_MS * lkr_pkg::CLK_KHZ
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        zeroUpKey,
  input  wire logic        zeroDownKey,
  input  wire logic        spanUpKey,
  input  wire logic        spanDownKey,
  input  wire logic [15:0] pressure,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] outValue,
  output logic      [15:0] displayValue,
  output logic      [15:0] barLow,
  output logic      [15:0] barHigh,
  output logic             calView,
  output logic             biasShow,
  output logic             locked
);
  localparam lkr_pkg::lkr_tmr_t T_VIEW  = lkr_pkg::lkr_tmr_t'(VIEW_CYC);
  localparam lkr_pkg::lkr_tmr_t T_COMBO = lkr_pkg::lkr_tmr_t'(COMBO_CYC);
  localparam lkr_pkg::lkr_tmr_t T_GAP   = lkr_pkg::lkr_tmr_t'(GAP_CYC);
  localparam lkr_pkg::lkr_tmr_t T_SLOW  = lkr_pkg::lkr_tmr_t'(SLOW_CYC);
  localparam lkr_pkg::lkr_tmr_t T_FAST  = lkr_pkg::lkr_tmr_t'(FAST_CYC);

  logic [3:0]          keys;
  logic [3:0]          keySet;
  logic [3:0]          keyAll;
  logic [3:0]          stepKeys;
  logic [3:0]          pairKeys;
  logic [3:0]          lastPair;
  logic [3:0]          repCnt;
  logic                stepReq;
  logic                pairDo;
  logic                viewArm;
  logic                biasArm;
  logic                apbAcc;
  lkr_pkg::lkr_state_t state;
  lkr_pkg::lkr_tmr_t   tmr;
  lkr_pkg::lkr_tmr_t   gapCnt;
  lkr_pkg::lkr_tmr_t   viewCnt;
  lkr_pkg::lkr_val_t   lowRange;
  lkr_pkg::lkr_val_t   highRange;
  lkr_pkg::lkr_val_t   bias;

  // One key down only, not a combination
  function automatic logic isSingle(input logic [3:0] k);
    return (k != 4'h0) && ((k & (k - 4'h1)) == 4'h0);
  endfunction

  // Two keys down exactly
  function automatic logic isPair(input logic [3:0] k);
    return $countones(k) == 2;
  endfunction

  assign keys   = {spanDownKey, spanUpKey, zeroDownKey, zeroUpKey};
  assign keyAll = keySet | keys;
  assign apbAcc = psel & penable & pready;

  // ---------------------------------------------------------------
  // Key interpreter
  // ---------------------------------------------------------------
  // Gather window merges near-simultaneous presses into one pattern
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= lkr_pkg::ST_IDLE;
      keySet   <= 4'h0;
      tmr      <= '0;
      repCnt   <= 4'h0;
      stepReq  <= 1'b0;
      stepKeys <= 4'h0;
      pairDo   <= 1'b0;
      pairKeys <= 4'h0;
      lastPair <= 4'h0;
      gapCnt   <= '0;
      viewArm  <= 1'b0;
      biasArm  <= 1'b0;
    end else begin
      stepReq <= 1'b0;
      pairDo  <= 1'b0;
      viewArm <= 1'b0;
      biasArm <= 1'b0;
      if (gapCnt != '0) begin
        gapCnt <= gapCnt - 1'b1;
      end
      // Lone bias pair with no second press just shows the bias
      if (gapCnt == 27'h0000001) begin
        lastPair <= 4'h0;
        biasArm  <= (lastPair == lkr_pkg::P_BIAS);
      end
      case (state)
        lkr_pkg::ST_IDLE: begin
          if (keys != 4'h0) begin
            keySet <= keys;
            tmr    <= T_COMBO;
            state  <= lkr_pkg::ST_GATHER;
          end
        end
        lkr_pkg::ST_GATHER: begin
          keySet <= keyAll;
          tmr    <= tmr - 1'b1;
          if (tmr == 27'h0000001) begin
            viewArm <= 1'b1;
            state   <= lkr_pkg::ST_RELEASE;
            if (isSingle(keyAll)) begin
              // Asleep display only wakes on the first press
              stepKeys <= calView ? keyAll : 4'h0;
              stepReq  <= calView;
              tmr      <= T_SLOW;
              repCnt   <= 4'h0;
              state    <= lkr_pkg::ST_HOLD;
            end else if (isPair(keyAll)) begin
              if (keyAll == lastPair && gapCnt != '0) begin
                pairDo   <= 1'b1;
                pairKeys <= keyAll;
                lastPair <= 4'h0;
                gapCnt   <= '0;
                biasArm  <= 1'b0;
              end else begin
                lastPair <= keyAll;
                gapCnt   <= T_GAP;
              end
            end
          end
        end
        lkr_pkg::ST_HOLD: begin
          if ((keys & keySet) == 4'h0) begin
            state <= lkr_pkg::ST_IDLE;
          end else if (tmr == 27'h0000001) begin
            stepReq <= (stepKeys != 4'h0);
            viewArm <= 1'b1;
            if (repCnt != 4'hF) begin
              repCnt <= repCnt + 4'h1;
            end
            // Slow steps first so single digits can be hit
            tmr <= (repCnt >= lkr_pkg::FAST_AFTER) ? T_FAST : T_SLOW;
          end else begin
            tmr <= tmr - 1'b1;
          end
        end
        default: begin
          // Wait for a clean release before a new pattern
          if (keys == 4'h0) begin
            state <= lkr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Range and bias store
  // ---------------------------------------------------------------
  // Key edits are dropped entirely while the point is locked
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowRange  <= lkr_pkg::LRV_RST;
      highRange <= lkr_pkg::URV_RST;
      bias      <= lkr_pkg::BIAS_RST;
    end else if (!locked) begin
      if (stepReq) begin
        case (stepKeys)
          lkr_pkg::K_ZU: lowRange <= lowRange + 16'h0001;
          lkr_pkg::K_ZD: lowRange <= lowRange - 16'h0001;
          lkr_pkg::K_SU: highRange <= highRange + 16'h0001;
          lkr_pkg::K_SD: highRange <= highRange - 16'h0001;
          default: ;
        endcase
      end
      if (pairDo) begin
        case (pairKeys)
          lkr_pkg::P_LRV: lowRange <= pressure;
          lkr_pkg::P_URV: highRange <= pressure;
          lkr_pkg::P_BIAS: bias <= pressure;
          lkr_pkg::P_BDEL: bias <= lkr_pkg::BIAS_RST;
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock flag
  // ---------------------------------------------------------------
  // Key pairs win over a software write in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b0;
    end else if (pairDo && pairKeys == lkr_pkg::P_LOCK) begin
      locked <= 1'b1;
    end else if (pairDo && pairKeys == lkr_pkg::P_UNLOCK) begin
      locked <= 1'b0;
    end else if (apbAcc && pwrite && paddr == lkr_pkg::A_CTRL) begin
      locked <= pwdata[lkr_pkg::CTRL_LOCK];
    end
  end

  // ---------------------------------------------------------------
  // View timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      viewCnt  <= '0;
      calView  <= 1'b0;
      biasShow <= 1'b0;
    end else if (viewArm || biasArm) begin
      viewCnt  <= T_VIEW;
      calView  <= 1'b1;
      biasShow <= biasArm;
    end else if (viewCnt != '0) begin
      viewCnt <= viewCnt - 1'b1;
      if (viewCnt == 27'h0000001) begin
        calView  <= 1'b0;
        biasShow <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output paths
  // ---------------------------------------------------------------
  // Bus value bypasses both ranges and bias; display sees bias only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outValue     <= 16'h0000;
      displayValue <= 16'h0000;
      barLow       <= lkr_pkg::LRV_RST;
      barHigh      <= lkr_pkg::URV_RST;
    end else begin
      outValue     <= pressure;
      displayValue <= biasShow ? bias : pressure - bias;
      barLow       <= lowRange;
      barHigh      <= highRange;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait state keeps read data coming straight from a flop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready) begin
        if (paddr == lkr_pkg::A_CTRL) begin
          prdata[lkr_pkg::CTRL_LOCK] <= locked;
        end else if (paddr == lkr_pkg::A_STAT) begin
          prdata[lkr_pkg::STAT_VIEW] <= calView;
          prdata[lkr_pkg::STAT_BIAS] <= biasShow;
          prdata[lkr_pkg::STAT_LOCK] <= locked;
        end else if (paddr == lkr_pkg::A_LRV) begin
          prdata[15:0] <= lowRange;
        end else if (paddr == lkr_pkg::A_URV) begin
          prdata[15:0] <= highRange;
        end else if (paddr == lkr_pkg::A_BIAS) begin
          prdata[15:0] <= bias;
        end else if (paddr == lkr_pkg::A_DISP) begin
          prdata[15:0] <= displayValue;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_bar_path: assert property (
    barLow == $past(lowRange) && barHigh == $past(highRange))
    else $error("bar graph does not follow range values");
  a_out_path: assert property (
    $past(reset_n) |-> outValue == $past(pressure))
    else $error("bus value not the raw pressure");
  a_zero_up: assert property (
    stepReq && stepKeys == lkr_pkg::K_ZU && !locked |=> lowRange == $past(lowRange) + 16'h0001)
    else $error("zero up step wrong");
  a_zero_down: assert property (
    stepReq && stepKeys == lkr_pkg::K_ZD && !locked |=> lowRange == $past(lowRange) - 16'h0001)
    else $error("zero down step wrong");
  a_span_up: assert property (
    stepReq && stepKeys == lkr_pkg::K_SU && !locked |=> highRange == $past(highRange) + 16'h0001)
    else $error("span up step wrong");
  a_span_down: assert property (
    stepReq && stepKeys == lkr_pkg::K_SD && !locked |=> highRange == $past(highRange) - 16'h0001)
    else $error("span down step wrong");
  a_first_wake: assert property (
    state == lkr_pkg::ST_GATHER && tmr == 27'h0000001 && isSingle(keyAll) && !calView
    |=> !stepReq && stepKeys == 4'h0 ##1 $stable(lowRange) && $stable(highRange))
    else $error("first press counted");
  a_hold_fast: assert property (
    state == lkr_pkg::ST_HOLD && (keys & keySet) != 4'h0 && tmr == 27'h0000001
    && repCnt >= lkr_pkg::FAST_AFTER |=> tmr == T_FAST)
    else $error("hold rate not raised");
  a_view_end: assert property (
    calView && viewCnt == 27'h0000001 && !viewArm && !biasArm |=> !calView && !biasShow)
    else $error("view did not time out");
  a_lrv_take: assert property (
    pairDo && pairKeys == lkr_pkg::P_LRV && !locked |=> lowRange == $past(pressure))
    else $error("lower range not captured");
  a_urv_take: assert property (
    pairDo && pairKeys == lkr_pkg::P_URV && !locked |=> highRange == $past(pressure))
    else $error("upper range not captured");
  a_bias_take: assert property (
    pairDo && pairKeys == lkr_pkg::P_BIAS && !locked |=> bias == $past(pressure))
    else $error("bias not captured");
  a_bias_show: assert property (
    biasArm |=> biasShow && calView && $stable(bias) ##1 displayValue == $past(bias))
    else $error("bias not shown");
  a_bias_clear: assert property (
    pairDo && pairKeys == lkr_pkg::P_BDEL && !locked |=> bias == lkr_pkg::BIAS_RST)
    else $error("bias not cleared");
  a_disp_bias: assert property (
    !biasShow && $past(reset_n) |=> displayValue == lkr_pkg::lkr_val_t'($past(pressure) - $past(bias)))
    else $error("display correction wrong");
  a_lock_hold: assert property (
    locked |=> $stable(lowRange) && $stable(highRange) && $stable(bias))
    else $error("locked point changed");
  a_combo_end: assert property (
    state == lkr_pkg::ST_GATHER && tmr == 27'h0000001 |=> state != lkr_pkg::ST_GATHER)
    else $error("gather window overran");
endmodule
`default_nettype wire

// [logic/lkr_pkg.sv]
// Purpose: Constants and types for the local key range block
// Assumes: 25 MHz core clock
// Notes:   Times in ms, cycle counts derived in the top module
package lkr_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ  = 25000;
  localparam int VIEW_MS  = 2000;
  localparam int COMBO_MS = 50;
  localparam int GAP_MS   = 1000;
  localparam int SLOW_MS  = 400;
  localparam int FAST_MS  = 60;
  localparam logic [3:0] FAST_AFTER = 4'h8;

  typedef logic [26:0] lkr_tmr_t;
  typedef logic [15:0] lkr_val_t;
  typedef enum logic [1:0] {ST_IDLE, ST_GATHER, ST_HOLD, ST_RELEASE} lkr_state_t;

  // ---------------------------------------------------------------
  // Keys and key pairs
  // ---------------------------------------------------------------
  localparam logic [3:0] K_ZU     = 4'h1;
  localparam logic [3:0] K_ZD     = 4'h2;
  localparam logic [3:0] K_SU     = 4'h4;
  localparam logic [3:0] K_SD     = 4'h8;
  localparam logic [3:0] P_LRV    = 4'h3;
  localparam logic [3:0] P_URV    = 4'hC;
  localparam logic [3:0] P_BIAS   = 4'h5;
  localparam logic [3:0] P_BDEL   = 4'hA;
  localparam logic [3:0] P_LOCK   = 4'h9;
  localparam logic [3:0] P_UNLOCK = 4'h6;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_LRV  = 8'h08;
  localparam logic [7:0] A_URV  = 8'h0C;
  localparam logic [7:0] A_BIAS = 8'h10;
  localparam logic [7:0] A_DISP = 8'h14;
  localparam int CTRL_LOCK = 0;
  localparam int STAT_VIEW = 0;
  localparam int STAT_BIAS = 1;
  localparam int STAT_LOCK = 2;
  localparam lkr_val_t LRV_RST  = 16'h0000;
  localparam lkr_val_t URV_RST  = 16'h03E8;
  localparam lkr_val_t BIAS_RST = 16'h0000;
endpackage

// [tb/lkr_operator.sv]
// Purpose: Operator model pressing the four local keys
// Assumes: Keys active high, changed just after core_clk rises
// Notes:   Pair keys are staggered to land inside one combination window
`timescale 1ns/10ps
`default_nettype none
module lkr_operator (
  input  wire logic       core_clk,
  output logic      [3:0] keys
);
  initial keys = 4'h0;

  // One press: lowest key first, partners two cycles later, then a full release
  task automatic press(input logic [3:0] pat, input int hold);
    logic [3:0] first;
    first = pat & (~pat + 4'h1);
    @(posedge core_clk);
    keys <= first;
    repeat (2) @(posedge core_clk);
    keys <= pat;
    repeat (hold) @(posedge core_clk);
    keys <= 4'h0;
    // Release long enough for the interpreter to go idle again
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the local key interpreter
// Assumes: Short timing parameters, one APB master, one operator model
// Notes:   Key rows in a loop, captures, bias, lock and bus cases by hand
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); fail_count++; end end
module testbench;
  typedef struct {logic [3:0] pat; logic [15:0] lo; logic [15:0] hi;} lkr_row_t;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [15:0] pressure = 16'h0200;
  logic [3:0]  keys;
  logic [31:0] prdata, d;
  logic        pready, pslverr, calView, biasShow, locked, er;
  logic [15:0] outValue, displayValue, barLow, barHigh, lo0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n;
  int          tq[$];
  lkr_row_t    rows [6] = '{'{4'h1, 16'h0000, 16'h03E8}, '{4'h1, 16'h0001, 16'h03E8},
    '{4'h1, 16'h0002, 16'h03E8}, '{4'h2, 16'h0001, 16'h03E8},
    '{4'h4, 16'h0001, 16'h03E9}, '{4'h8, 16'h0001, 16'h03E8}};

  always #20 core_clk = ~core_clk;

  lkr_key_range #(.VIEW_CYC(200), .COMBO_CYC(4), .GAP_CYC(40), .SLOW_CYC(20), .FAST_CYC(6))
  u_lkr_key_range (.core_clk(core_clk), .reset_n(reset_n), .zeroUpKey(keys[0]),
    .zeroDownKey(keys[1]), .spanUpKey(keys[2]), .spanDownKey(keys[3]), .pressure(pressure),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .outValue(outValue),
    .displayValue(displayValue), .barLow(barLow), .barHigh(barHigh), .calView(calView),
    .biasShow(biasShow), .locked(locked));

  lkr_operator u_lkr_operator (.core_clk(core_clk), .keys(keys));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results();
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Request held until pready is seen high; a lost answer ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    // Pre-edge values seen here are what the slave shows at this rising edge
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    d  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Same pair twice, then let the pairing gap run out
  task automatic twice(input logic [3:0] pat);
    u_lkr_operator.press(pat, 8);
    u_lkr_operator.press(pat, 8);
    repeat (45) @(negedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (11) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("barHighRst", 16'h03E8, barHigh)
    `CHK("barLowRst", 16'h0000, barLow)
    `CHK("viewRst", 1'b0, calView)
    @(posedge core_clk);
    reset_n <= 1'b1;
    // Ordinary single presses: wake first, then one digit each
    for (int i = 0; i < 6; i++) begin
      u_lkr_operator.press(rows[i].pat, 8);
      `CHK("barLow", rows[i].lo, barLow)
      `CHK("barHigh", rows[i].hi, barHigh)
      `CHK("calView", 1'b1, calView)
      `CHK("outValue", 16'h0200, outValue)
      `CHK("display", 16'h0200, displayValue)
    end
    // Held key: slow repeat first, faster later
    lo0 = barLow;
    fork
      u_lkr_operator.press(lkr_pkg::K_ZU, 400);
      for (int c = 0; c < 420; c++) begin
        @(negedge core_clk);
        if (barLow !== lo0 + 16'(tq.size())) tq.push_back(c);
      end
    join
    `CHK("holdSteps", 1'b1, tq.size() > 12)
    `CHK("slowGap", 20, tq[3] - tq[2])
    `CHK("fastGap", 6, tq[$] - tq[$-1])
    // 400-cycle hold: step on the initial press, nine slow steps, then 36 fast ones
    `CHK("holdEnd", lo0 + 16'h002E, barLow)
    // Return to measurement view after the idle time
    n = 0;
    while (calView === 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("viewBack", 1'b1, n > 150 && n < 200)
    // Captures of the acting pressure
    @(posedge core_clk);
    pressure <= 16'h0123;
    twice(lkr_pkg::P_LRV);
    `CHK("lrvCap", 16'h0123, barLow)
    @(posedge core_clk);
    pressure <= 16'h0456;
    twice(lkr_pkg::P_URV);
    `CHK("urvCap", 16'h0456, barHigh)
    @(posedge core_clk);
    pressure <= 16'h0010;
    twice(lkr_pkg::P_BIAS);
    apb(1'b0, lkr_pkg::A_BIAS, 32'h0);
    `CHK("biasCap", 32'h0010, d)
    @(posedge core_clk);
    pressure <= 16'h0100;
    repeat (3) @(negedge core_clk);
    `CHK("dispBias", 16'h00F0, displayValue)
    `CHK("outBias", 16'h0100, outValue)
    `CHK("barKeep", 16'h0123, barLow)
    u_lkr_operator.press(lkr_pkg::P_BIAS, 8);
    repeat (45) @(negedge core_clk);
    `CHK("biasShow", 1'b1, biasShow)
    `CHK("biasDisp", 16'h0010, displayValue)
    // Lock ignores deletes and steps, unlock restores them
    twice(lkr_pkg::P_LOCK);
    `CHK("locked", 1'b1, locked)
    twice(lkr_pkg::P_BDEL);
    twice(lkr_pkg::K_ZU);
    apb(1'b0, lkr_pkg::A_BIAS, 32'h0);
    `CHK("lockBias", 32'h0010, d)
    `CHK("lockStep", 16'h0123, barLow)
    twice(lkr_pkg::P_UNLOCK);
    `CHK("unlocked", 1'b0, locked)
    twice(lkr_pkg::P_BDEL);
    apb(1'b0, lkr_pkg::A_BIAS, 32'h0);
    `CHK("biasDel", 32'h0000, d)
    repeat (210) @(negedge core_clk);
    `CHK("dispNoBias", 16'h0100, displayValue)
    // Bus side: lock bit, read-only place, unmapped place
    apb(1'b1, lkr_pkg::A_CTRL, 32'h1);
    apb(1'b0, lkr_pkg::A_STAT, 32'h0);
    `CHK("statLock", 1'b1, d[lkr_pkg::STAT_LOCK])
    apb(1'b1, lkr_pkg::A_CTRL, 32'h0);
    apb(1'b1, lkr_pkg::A_LRV, 32'hFFFF);
    apb(1'b0, lkr_pkg::A_LRV, 32'h0);
    `CHK("lrvRo", 32'h0123, d)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapErr", 1'b1, er)
    `CHK("unmapData", 32'h0, d)
    results();
  end
endmodule
`default_nettype wire
